// ===== sim/ahrp_host_model.sv
// Behavioural processor model that drives the host pins of the port.
// Assumes the bench resolves the data bus from this model and the port.
`timescale 1ns/1ps

module ahrp_host_model (
    input wire logic clk_in,
    output logic cs_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic ale_out,
    output ahrp_pkg::ahrp_addr_t addr_out,
    output ahrp_pkg::ahrp_data_t data_out
);
    import ahrp_pkg::*;

    initial begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        ale_out = 1'b1;
        addr_out = 8'h00;
        data_out = 8'h00;
    end

    // One strobe pulse; the strobe is raised before chip select.
    task automatic access(input logic is_rd, input logic sel_n,
                          input ahrp_addr_t a, input ahrp_data_t d);
        @(negedge clk_in);
        addr_out = a;
        data_out = is_rd ? ~data_out : d;
        cs_n_out = sel_n;
        if (is_rd) rd_n_out = 1'b0;
        else wr_n_out = 1'b0;
        repeat (6) @(negedge clk_in);
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        repeat (4) @(negedge clk_in);
        cs_n_out = 1'b1;
        data_out = ~data_out;
        repeat (4) @(negedge clk_in);
    endtask

    task automatic set_ale(input logic v);
        @(negedge clk_in);
        ale_out = v;
        repeat (4) @(negedge clk_in);
    endtask
endmodule // ahrp_host_model

// ===== sim/tb.sv
// Self-checking bench of the host register port.
// Assumes the design sources and ahrp_host_model are compiled first.
`timescale 1ns/1ps
`define CHECK(nm, got, exp) begin samples_checked++; if ((got) !== (exp)) \
    begin fails++; $display("[FAIL] %s exp=%h got=%h", nm, exp, got); end end

module tb;
    import ahrp_pkg::*;

    logic clk = 1'b0;
    logic reset_in = 1'b1;
    logic reset_in_n = 1'b1;
    logic cs_n, rd_n, wr_n, ale, oe, oe_q, test_mode;
    ahrp_addr_t addr;
    ahrp_data_t h_data, d_out, bus, exp, mem [8];
    int fails = 0;
    int samples_checked = 0;
    int seed = 32'hBCCB6DC8;
    ahrp_data_t notes [$];

    initial forever #5 clk = ~clk;
    assign bus = oe ? d_out : h_data;

    ahrp_host_model host (.clk_in(clk), .cs_n_out(cs_n), .rd_n_out(rd_n),
        .wr_n_out(wr_n), .ale_out(ale), .addr_out(addr), .data_out(h_data));

    ahrp_host_port uut (.ref_clk_in(clk), .reset_in(reset_in),
        .reset_in_n(reset_in_n), .chip_select_n_in(cs_n),
        .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n), .ale_in(ale),
        .addr_in(addr), .data_in(bus), .data_out(d_out),
        .data_oe_out(oe), .test_mode_out(test_mode));

    ////////////////////////////////////////////////////////////////////////
    // Each rising output enable takes the oldest noted read value.
    always @(posedge clk) begin
        oe_q <= oe;
        if (oe === 1'b1 && oe_q !== 1'b1) begin
            if (notes.size() == 0) begin
                fails++;
                $display("[FAIL] read_data exp=none got=%h", d_out);
            end else begin
                exp = notes.pop_front();
                #1 `CHECK("read_data", d_out, exp)
            end
        end
    end

    task automatic rd(input ahrp_addr_t a, input ahrp_data_t e);
        notes.push_back(e);
        host.access(1'b1, 1'b0, a, 8'h00);
        `CHECK("oe_idle", {oe, d_out}, 9'h000)
    endtask

    task automatic test_done;
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #100000;
        fails++;
        test_done;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        // Drop the pin after time zero so the asynchronous reset sees an edge.
        #1 reset_in_n = 1'b0;
        repeat (16) @(negedge clk);
        reset_in = 1'b0;
        reset_in_n = 1'b1;
        repeat (8) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            mem[i] = 8'($random(seed));
            host.access(1'b0, 1'b0, {i[3:0], 4'h5}, mem[i]);
        end
        host.access(1'b0, 1'b1, 8'h05, ~mem[0]);
        host.access(1'b1, 1'b1, 8'h05, 8'h00);
        for (int i = 0; i < 8; i++) rd({i[3:0], 4'h5}, mem[i]);
        host.access(1'b0, 1'b0, 8'hF0, 8'hA5);
        host.set_ale(1'b0);
        host.access(1'b0, 1'b0, 8'hF1, 8'h3C);
        host.set_ale(1'b1);
        rd(8'hF0, 8'h3C);
        rd(8'hF1, 8'h00);
        notes.push_back(mem[1]);
        fork
            host.access(1'b1, 1'b0, 8'h15, 8'h00);
            begin
                repeat (5) @(negedge clk);
                #3 reset_in_n = 1'b0;
                #1 `CHECK("oe_async", oe, 1'b0)
                `CHECK("test_mode_rst", test_mode, 1'b1)
                repeat (4) @(negedge clk);
                reset_in_n = 1'b1;
                @(posedge clk);
                #1 `CHECK("test_mode_sync", test_mode, 1'b1)
            end
        join
        repeat (10) @(negedge clk);
        `CHECK("test_mode_clr", test_mode, 1'b0)
        rd(8'h15, 8'h00);
        test_done;
    end
endmodule // tb

// ===== src/ahrp_defines.svh
// Constants of the asynchronous host register port.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef AHRP_DEFINES_SVH
`define AHRP_DEFINES_SVH

`define AHRP_ADDR_W 8
`define AHRP_DATA_W 8
`define AHRP_SYNC_STAGES 2
`define AHRP_REG_RESET 8'h00
`define AHRP_ADDR_RESET 8'h00
`define AHRP_CLK_PERIOD_NS 10

`endif

// ===== src/ahrp_host_port.sv
// Asynchronous 8-bit parallel host port with address latch.
// Assumes host pins are asynchronous to ref_clk_in and the data pin is
// resolved outside from data_out and data_oe_out.
//
// Function
// - Data is stored on the rising edge of write strobe OR chip select.
// - While the latch enable is low the latched address is held.
// - While the latch enable is high the address passes straight through.
// - A low reset pin resets all logic at once, without a clock edge; test mode is set.
// - The address selects at most one register for each access.
// - Data is driven only while read strobe and chip select are both low.
// - Accesses need chip select low; chip select high clears test mode.
`timescale 1ns/1ps
`include "ahrp_defines.svh"

module ahrp_host_port #(
    parameter int SYNC_STAGES = `AHRP_SYNC_STAGES,
    parameter int DEPTH = 256
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic reset_in_n,
    input wire logic chip_select_n_in,
    input wire logic read_strobe_n_in,
    input wire logic write_strobe_n_in,
    input wire logic ale_in,
    input wire ahrp_pkg::ahrp_addr_t addr_in,
    input wire ahrp_pkg::ahrp_data_t data_in,
    output ahrp_pkg::ahrp_data_t data_out,
    output logic data_oe_out,
    output logic test_mode_out
);
    import ahrp_pkg::*;

    if (SYNC_STAGES != 2) begin : g_bad_sync
        $error("ahrp_host_port: only two sync stages supported");
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset: asserts at once from the pin, releases on the clock.

    logic rst_meta_q;
    logic rst_sync_q;
    logic srst;

    always_ff @(posedge ref_clk_in or negedge reset_in_n) begin
        if (!reset_in_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign srst = reset_in | ~rst_sync_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    ahrp_pins_s pins_raw;
    ahrp_pins_s pins_meta_q;
    ahrp_pins_s pins_q;

    assign pins_raw = '{chip_select_n: chip_select_n_in,
                        read_strobe_n: read_strobe_n_in,
                        write_strobe_n: write_strobe_n_in,
                        ale: ale_in, addr: addr_in, data: data_in};

    // Strobes rest high so a reset cannot fake an access. Chip select
    // rests low so that a reset is not taken for the host raising it,
    // which would clear test mode before the host ever deselected.
    localparam ahrp_pins_s PINS_IDLE = '{chip_select_n: 1'b0,
                                        read_strobe_n: 1'b1,
                                        write_strobe_n: 1'b1,
                                        ale: 1'b1,
                                        addr: `AHRP_ADDR_RESET,
                                        data: `AHRP_REG_RESET};

    always_ff @(posedge ref_clk_in or negedge reset_in_n) begin
        if (!reset_in_n) begin
            pins_meta_q <= PINS_IDLE;
            pins_q <= PINS_IDLE;
        end else if (srst) begin
            pins_meta_q <= PINS_IDLE;
            pins_q <= PINS_IDLE;
        end else begin
            pins_meta_q <= pins_raw;
            pins_q <= pins_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address latch.

    ahrp_addr_t addr_lat_q;
    ahrp_addr_t addr_eff;

    always_ff @(posedge ref_clk_in or negedge reset_in_n) begin
        if (!reset_in_n) begin
            addr_lat_q <= `AHRP_ADDR_RESET;
        end else if (srst) begin
            addr_lat_q <= `AHRP_ADDR_RESET;
        end else if (pins_q.ale) begin
            addr_lat_q <= pins_q.addr;
        end
    end

    // Low latch enable holds the last address seen while it was high.
    assign addr_eff = pins_q.ale ? pins_q.addr : addr_lat_q;

    ////////////////////////////////////////////////////////////////////////
    // Write strobe edge and register array.

    logic strobe;
    logic strobe_q;
    ahrp_wr_s wr;
    ahrp_data_t rdata;

    // Write strobe OR chip select; a rise ends the access.
    assign strobe = pins_q.write_strobe_n | pins_q.chip_select_n;

    always_ff @(posedge ref_clk_in or negedge reset_in_n) begin
        if (!reset_in_n) begin
            strobe_q <= 1'b1;
        end else if (srst) begin
            strobe_q <= 1'b1;
        end else begin
            strobe_q <= strobe;
        end
    end

    // A low combined strobe before the rise proves chip select was low.
    assign wr.en = strobe & ~strobe_q;
    assign wr.addr = addr_eff;
    assign wr.data = pins_q.data;

    ahrp_regfile #(
        .DEPTH(DEPTH)
    ) u_regs (
        .ref_clk_in(ref_clk_in),
        .arst_n_in(reset_in_n),
        .srst_in(srst),
        .wr_in(wr),
        .raddr_in(addr_eff),
        .rdata_out(rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read drive.

    logic rd_sel;

    assign rd_sel = ~pins_q.read_strobe_n & ~pins_q.chip_select_n;

    always_ff @(posedge ref_clk_in or negedge reset_in_n) begin
        if (!reset_in_n) begin
            data_oe_out <= 1'b0;
            data_out <= `AHRP_REG_RESET;
        end else if (srst) begin
            data_oe_out <= 1'b0;
            data_out <= `AHRP_REG_RESET;
        end else begin
            data_oe_out <= rd_sel;
            data_out <= rd_sel ? rdata : `AHRP_REG_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test mode: set by a low reset pin (not by reset_in), cleared by the first chip select high.

    always_ff @(posedge ref_clk_in or negedge reset_in_n) begin
        if (!reset_in_n) begin
            test_mode_out <= 1'b1;
        end else if (pins_q.chip_select_n) begin
            test_mode_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    a_write_on_rise: assert property (@(posedge ref_clk_in) disable iff (srst)
        wr.en |-> $past(strobe) == 1'b0 && strobe)
        else $error("write not on strobe rise");

    a_write_needs_cs: assert property (@(posedge ref_clk_in)
        disable iff (srst)
        wr.en |-> $past(pins_q.chip_select_n) == 1'b0)
        else $error("write without chip select");

    a_latch_holds: assert property (@(posedge ref_clk_in) disable iff (srst)
        !pins_q.ale ##1 !pins_q.ale |-> $stable(addr_lat_q))
        else $error("address latch moved while closed");

    a_latch_passes: assert property (@(posedge ref_clk_in)
        disable iff (srst)
        pins_q.ale |-> addr_eff == pins_q.addr
            ##1 addr_lat_q == $past(pins_q.addr))
        else $error("address latch not transparent");

    a_read_drive: assert property (@(posedge ref_clk_in) disable iff (srst)
        rd_sel |=> data_oe_out && data_out == $past(rdata))
        else $error("read data not driven");

    a_read_release: assert property (@(posedge ref_clk_in)
        disable iff (srst)
        !rd_sel |=> !data_oe_out)
        else $error("data driven outside read");

    a_pin_reset: assert property (@(posedge ref_clk_in)
        !reset_in_n |-> !data_oe_out && test_mode_out)
        else $error("pin reset did not clear outputs");

    a_reset_release: assert property (@(posedge ref_clk_in)
        $rose(reset_in_n) |-> srst [*2])
        else $error("reset released without synchronisation");

    a_test_clear: assert property (@(posedge ref_clk_in) disable iff (srst)
        pins_q.chip_select_n |=> !test_mode_out)
        else $error("test mode not cleared");

    c_write: cover property (@(posedge ref_clk_in) disable iff (srst)
        wr.en);

    c_read: cover property (@(posedge ref_clk_in) disable iff (srst)
        rd_sel ##1 data_oe_out);

    c_muxed_write: cover property (@(posedge ref_clk_in) disable iff (srst)
        !pins_q.ale [*2] ##1 wr.en);

    c_test_exit: cover property (@(posedge ref_clk_in)
        $fell(test_mode_out));

endmodule // ahrp_host_port

// ===== src/ahrp_pkg.sv
// Types shared by the host register port modules.
// Assumes ahrp_defines.svh is on the include path.
`include "ahrp_defines.svh"

package ahrp_pkg;

    typedef logic [`AHRP_ADDR_W-1:0] ahrp_addr_t;
    typedef logic [`AHRP_DATA_W-1:0] ahrp_data_t;

    // One sampled view of the host pins.
    typedef struct packed {
        logic chip_select_n;
        logic read_strobe_n;
        logic write_strobe_n;
        logic ale;
        ahrp_addr_t addr;
        ahrp_data_t data;
    } ahrp_pins_s;

    // A write into the register array.
    typedef struct packed {
        logic en;
        ahrp_addr_t addr;
        ahrp_data_t data;
    } ahrp_wr_s;

endpackage

// ===== src/ahrp_regfile.sv
// Register array of the host port: one write port, one read port.
// Assumes the caller provides a synchronous write request and reset.
`timescale 1ns/1ps
`include "ahrp_defines.svh"

module ahrp_regfile #(
    parameter int DEPTH = 256
) (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic srst_in,
    input wire ahrp_pkg::ahrp_wr_s wr_in,
    input wire ahrp_pkg::ahrp_addr_t raddr_in,
    output ahrp_pkg::ahrp_data_t rdata_out
);
    import ahrp_pkg::*;

    if (DEPTH < 1 || DEPTH > (1 << `AHRP_ADDR_W)) begin : g_bad_depth
        $error("ahrp_regfile: DEPTH out of range");
    end

    ahrp_data_t mem_q [DEPTH];

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= `AHRP_REG_RESET;
            end
        end else if (srst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= `AHRP_REG_RESET;
            end
        end else if (wr_in.en && (int'(wr_in.addr) < DEPTH)) begin
            mem_q[wr_in.addr] <= wr_in.data;
        end
    end

    // Unpopulated addresses read as zero.
    assign rdata_out = (int'(raddr_in) < DEPTH) ? mem_q[raddr_in]
                                                 : `AHRP_REG_RESET;

endmodule // ahrp_regfile
